// ---- dma_channel_b_full_address_control.sv ----
// Full address mode control of one DMA channel with APB register access
// Assumes pclk at 20 MHz, APB master, stream source and sink on pclk
`timescale 1ns/10ps
`include "dma_regs.svh"
module dma_channel_b_full_address_control
  import dma_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [11:0]            paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   ext_req_n,
  input  wire logic [3:0]             timer_match,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [`DATA_WIDTH-1:0] in_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [`DATA_WIDTH-1:0]      out_data,
  output logic [23:0]                 out_src_addr,
  output logic [23:0]                 out_dst_addr,
  output logic                        out_word
);
  dma_trig_if t ();

  logic [7:0]             ctrl_a_r;
  logic [7:0]             ctrl_b_r;
  logic [7:0]             io_addr_1a_r;
  logic [7:0]             block_len_r;
  logic [7:0]             blk_cnt_r;
  addr_t                  src_addr_r;
  addr_t                  dst_addr_r;
  addr_t                  src_start_r;
  addr_t                  dst_start_r;
  addr_t                  src_nxt;
  addr_t                  dst_nxt;
  eng_e                   eng_r;
  logic                   gap_r;
  logic                   out_valid_r;
  logic [`DATA_WIDTH-1:0] out_data_r;
  addr_t                  out_src_r;
  addr_t                  out_dst_r;
  logic                   out_word_r;
  logic [31:0]            prdata_r;
  logic [31:0]            rdata_nxt;
  logic [7:0]             idx;
  logic                   hit;
  logic                   wr;
  logic                   fifo_v;
  logic                   fifo_pop;
  logic [`DATA_WIDTH-1:0] fifo_d;
  logic [3:0]             fifo_level;
  logic                   en;
  logic                   word;
  logic                   block_mode;
  logic                   area_src;
  logic                   can_go;
  logic                   start_blk;
  logic                   fire;
  logic                   blk_last;
  logic                   wr_src;
  logic                   wr_dst;

  function automatic logic mapped(logic [7:0] i);
    return i == `IDX_CTRL_A || i == `IDX_CTRL_B || i == `IDX_SRC_ADDR ||
           i == `IDX_DST_ADDR || i == `IDX_BLOCK_LEN || i == `IDX_STATUS ||
           i == `IDX_IOADDR_1A;
  endfunction

  // APB decode: word aligned, zero wait states
  assign idx     = paddr[9:2];
  assign hit     = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) && mapped(idx);
  assign wr      = psel && penable && pwrite && hit;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_r;
  assign wr_src  = wr && idx == `IDX_SRC_ADDR;
  assign wr_dst  = wr && idx == `IDX_DST_ADDR;

  assign en         = ctrl_b_r[`BIT_MASTER_EN];
  assign word       = ctrl_a_r[`BIT_SIZE];
  assign block_mode = ctrl_a_r[`BIT_BLOCK_MODE];
  assign area_src   = ctrl_b_r[`BIT_BLOCK_AREA];

  // Control B: bit 6 stored but unused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_b_r <= `CTRL_B_RESET;
    else if (wr && idx == `IDX_CTRL_B) ctrl_b_r <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_r    <= `CTRL_A_RESET;
      block_len_r <= `BLOCK_LEN_RESET;
    end else begin
      if (wr && idx == `IDX_CTRL_A)    ctrl_a_r    <= pwdata[7:0];
      if (wr && idx == `IDX_BLOCK_LEN) block_len_r <= pwdata[7:0];
    end
  end

  // Not reset: contents undefined until written
  always_ff @(posedge pclk) begin
    if (wr && idx == `IDX_IOADDR_1A) io_addr_1a_r <= pwdata[7:0];
  end

  always_comb begin
    rdata_nxt = 32'h00000000;
    unique case (idx)
      `IDX_CTRL_A:    rdata_nxt[7:0]  = ctrl_a_r;
      `IDX_CTRL_B:    rdata_nxt[7:0]  = ctrl_b_r;
      `IDX_SRC_ADDR:  rdata_nxt[23:0] = src_addr_r;
      `IDX_DST_ADDR:  rdata_nxt[23:0] = dst_addr_r;
      `IDX_BLOCK_LEN: rdata_nxt[7:0]  = block_len_r;
      `IDX_STATUS:    rdata_nxt[15:0] = {blk_cnt_r, fifo_level, 1'b0, t.pending,
                                         t.req, eng_r == ENG_BLOCK};
      `IDX_IOADDR_1A: rdata_nxt[7:0]  = io_addr_1a_r;
      default:        rdata_nxt       = 32'h00000000;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_r <= 32'h00000000;
    else if (psel && !penable && !pwrite) prdata_r <= hit ? rdata_nxt : 32'h00000000;
  end

  dma_fifo #(
    .WIDTH (`DATA_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_data),
    .out_valid (fifo_v),
    .out_ready (fifo_pop),
    .out_data  (fifo_d),
    .level     (fifo_level)
  );

  assign t.enable     = en;
  assign t.block_mode = block_mode;
  assign t.source     = ctrl_b_r[2:0];

  dma_trigger u_trig (
    .pclk        (pclk),
    .presetn     (presetn),
    .ext_req_n   (ext_req_n),
    .timer_match (timer_match),
    .t           (t)
  );

  // Transfer qualification
  always_comb begin
    can_go    = 1'b0;
    start_blk = 1'b0;
    if (en) begin
      if (!block_mode) can_go = t.req && !gap_r;
      else if (eng_r == ENG_BLOCK) can_go = 1'b1;
      else start_blk = t.req;
    end
  end

  assign fire     = can_go && fifo_v && (!out_valid_r || out_ready);
  assign fifo_pop = fire;
  assign blk_last = (eng_r == ENG_BLOCK) && (blk_cnt_r <= 8'h01);
  assign t.ack    = (fire && !block_mode) || start_blk;

  // Cycle steal leaves one idle cycle after each transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_r <= 1'b0;
    else gap_r <= fire && !block_mode && ctrl_b_r[2:0] == `SRC_AUTO_STEAL;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_r     <= ENG_IDLE;
      blk_cnt_r <= 8'h00;
    end else if (!en || !block_mode) begin
      eng_r     <= ENG_IDLE;
      blk_cnt_r <= 8'h00;
    end else if (start_blk) begin
      eng_r     <= ENG_BLOCK;
      blk_cnt_r <= block_len_r;
    end else if (fire) begin
      blk_cnt_r <= blk_cnt_r - 8'h01;
      if (blk_last) eng_r <= ENG_IDLE;
    end
  end

  assign src_nxt = step_addr(src_addr_r, ctrl_a_r[`BIT_SRC_STEP],
                             ctrl_a_r[`BIT_SRC_DIR], word);
  assign dst_nxt = step_addr(dst_addr_r, ctrl_b_r[`BIT_DST_STEP],
                             ctrl_b_r[`BIT_DST_DIR], word);

  // Block area side returns to its start when a block ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_addr_r  <= `ADDR_RESET;
      src_start_r <= `ADDR_RESET;
    end else if (wr_src) begin
      src_addr_r  <= pwdata[23:0];
      src_start_r <= pwdata[23:0];
    end else if (fire) begin
      src_addr_r <= (blk_last && area_src) ? src_start_r : src_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dst_addr_r  <= `ADDR_RESET;
      dst_start_r <= `ADDR_RESET;
    end else if (wr_dst) begin
      dst_addr_r  <= pwdata[23:0];
      dst_start_r <= pwdata[23:0];
    end else if (fire) begin
      dst_addr_r <= (blk_last && !area_src) ? dst_start_r : dst_nxt;
    end
  end

  // Output stage: byte size keeps only the low byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
      out_src_r   <= `ADDR_RESET;
      out_dst_r   <= `ADDR_RESET;
      out_word_r  <= 1'b0;
    end else if (fire) begin
      out_valid_r <= 1'b1;
      out_data_r  <= word ? fifo_d : {{(`DATA_WIDTH-8){1'b0}}, fifo_d[7:0]};
      out_src_r   <= src_addr_r;
      out_dst_r   <= dst_addr_r;
      out_word_r  <= word;
    end else if (out_ready) begin
      out_valid_r <= 1'b0;
    end
  end

  assign out_valid    = out_valid_r;
  assign out_data     = out_data_r;
  assign out_src_addr = out_src_r;
  assign out_dst_addr = out_dst_r;
  assign out_word     = out_word_r;

  // Checks of activation, gating and address stepping
  a_ctrl_b_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == `IDX_CTRL_B) |=> ctrl_b_r == $past(pwdata[7:0]))
    else $error("control B did not take the written value");

  a_enable_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !en |-> !fire && !out_valid_r ##0 1 or en)
    else $error("transfer started while disabled");

  a_burst_auto: assert property (@(posedge pclk) disable iff (!presetn)
    (en && !block_mode && ctrl_b_r[2:0] == `SRC_AUTO_BURST && fifo_v && !out_valid_r)
    |-> fire)
    else $error("burst auto request did not transfer");

  a_steal_gap: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && !block_mode && ctrl_b_r[2:0] == `SRC_AUTO_STEAL) |=> !fire)
    else $error("cycle steal transfers ran back to back");

  a_dst_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && !ctrl_b_r[`BIT_DST_STEP] && !wr_dst && !blk_last)
    |=> $stable(dst_addr_r))
    else $error("fixed destination address moved");

  a_dst_up: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && ctrl_b_r[`BIT_DST_STEP] && !ctrl_b_r[`BIT_DST_DIR] && !wr_dst && !blk_last)
    |=> dst_addr_r == $past(dst_addr_r) + ($past(word) ? 24'h000002 : 24'h000001))
    else $error("destination did not step up by the size");

  a_dst_down: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && ctrl_b_r[`BIT_DST_STEP] && ctrl_b_r[`BIT_DST_DIR] && !wr_dst && !blk_last)
    |=> dst_addr_r == $past(dst_addr_r) - ($past(word) ? 24'h000002 : 24'h000001))
    else $error("destination did not step down by the size");

  a_src_step: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && ctrl_a_r[`BIT_SRC_STEP] && !ctrl_a_r[`BIT_SRC_DIR] && !wr_src && !blk_last)
    |=> src_addr_r == $past(src_addr_r) + ($past(word) ? 24'h000002 : 24'h000001))
    else $error("source did not step up by the size");

  a_src_down: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && ctrl_a_r[`BIT_SRC_STEP] && ctrl_a_r[`BIT_SRC_DIR] && !wr_src && !blk_last)
    |=> src_addr_r == $past(src_addr_r) - ($past(word) ? 24'h000002 : 24'h000001))
    else $error("source did not step down by the size");

  a_src_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && !ctrl_a_r[`BIT_SRC_STEP] && !wr_src && !blk_last)
    |=> $stable(src_addr_r))
    else $error("fixed source address moved");

  a_block_reload: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && blk_last && !area_src && !wr_dst) |=> dst_addr_r == $past(dst_start_r))
    else $error("destination block area did not return to its start");

  a_src_reload: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && blk_last && area_src && !wr_src) |=> src_addr_r == $past(src_start_r))
    else $error("source block area did not return to its start");

  a_src_walks_on: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && blk_last && !area_src && !wr_src) |=> src_addr_r == $past(src_nxt))
    else $error("non block side did not keep stepping");

  a_bad_code_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (!block_mode && ctrl_b_r[2:1] == 2'b10) |-> !t.req)
    else $error("unavailable code produced a request");

  a_disable_abort: assert property (@(posedge pclk) disable iff (!presetn)
    !en |=> eng_r == ENG_IDLE && !t.pending)
    else $error("disabled channel kept a block or request");

  a_pin_edge_req: assert property (@(posedge pclk) disable iff (!presetn)
    (en && !block_mode && ctrl_b_r[2:0] == `SRC_PIN_EDGE && t.pending) |-> t.req)
    else $error("latched pin edge gave no request");

  a_block_start: assert property (@(posedge pclk) disable iff (!presetn)
    (en && block_mode && eng_r == ENG_IDLE && t.req) |=> eng_r == ENG_BLOCK)
    else $error("block request did not start a block");

  a_level_block_none: assert property (@(posedge pclk) disable iff (!presetn)
    (en && block_mode && ctrl_b_r[2:0] == `SRC_PIN_LEVEL && !t.pending) |=> !t.pending)
    else $error("low level pin requested in block mode");
endmodule // dma_channel_b_full_address_control

// ---- dma_regs.svh ----
// Register indexes, field positions, reset values and counts of the channel
// Assumes APB byte addressing: byte address is four times the index
`ifndef DMA_REGS_SVH
`define DMA_REGS_SVH
`define IDX_SRC_ADDR    8'h20
`define IDX_CTRL_A      8'h27
`define IDX_DST_ADDR    8'h28
`define IDX_CTRL_B      8'h2F
`define IDX_BLOCK_LEN   8'h30
`define IDX_STATUS      8'h31
`define IDX_IOADDR_1A   8'h36
`define CTRL_A_RESET    8'h00
`define CTRL_B_RESET    8'h00
`define BLOCK_LEN_RESET 8'h01
`define ADDR_RESET      24'h000000
`define BIT_MASTER_EN   7
`define BIT_SPARE       6
`define BIT_DST_DIR     5
`define BIT_DST_STEP    4
`define BIT_BLOCK_AREA  3
`define BIT_SIZE        6
`define BIT_SRC_DIR     5
`define BIT_SRC_STEP    4
`define BIT_BLOCK_MODE  0
`define SRC_AUTO_BURST  3'h0
`define SRC_AUTO_STEAL  3'h2
`define SRC_PIN_EDGE    3'h6
`define SRC_PIN_LEVEL   3'h7
`define STEP_BYTE       24'h000001
`define STEP_WORD       24'h000002
`define FIFO_DEPTH      8
`define DATA_WIDTH      16
`endif

// ---- dma_pkg.sv ----
// Types and the shared address step function of the channel
// Assumes dma_regs.svh on the include path
`include "dma_regs.svh"
package dma_pkg;
  typedef logic [23:0] addr_t;
  typedef enum {ENG_IDLE, ENG_BLOCK} eng_e;

  function automatic addr_t step_addr(addr_t a, logic en, logic dir, logic word);
    addr_t d;
    d = word ? `STEP_WORD : `STEP_BYTE;
    if (!en) return a;
    return dir ? a - d : a + d;
  endfunction
endpackage

// ---- dma_trig_if.sv ----
// Link between the channel control and its activation source selector
// Assumes both ends run on pclk
`timescale 1ns/10ps
interface dma_trig_if;
  logic       enable;
  logic       block_mode;
  logic [2:0] source;
  logic       ack;
  logic       req;
  logic       pending;
  modport ctl (output enable, output block_mode, output source, output ack,
               input req, input pending);
  modport sel (input enable, input block_mode, input source, input ack,
               output req, output pending);
endinterface

// ---- dma_fifo.sv ----
// Data buffer between the stream input and the transfer engine
// Assumes a single clock; no reading while empty, no writing while full
`timescale 1ns/10ps
module dma_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign level     = count_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge pclk) begin
    if (push) mem[wr_ptr_r] <= in_data;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      if (pop)  rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // dma_fifo

// ---- dma_trigger.sv ----
// Activation source selector: auto request, timer events and request pin
// Assumes timer events are pclk pulses; the request pin is asynchronous
`timescale 1ns/10ps
`include "dma_regs.svh"
module dma_trigger
  import dma_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ext_req_n,
  input  wire logic [3:0] timer_match,
  dma_trig_if.sel         t
);
  logic meta_r, sync_r, prev_r, pending_r, fall, evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= ext_req_n;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign fall = prev_r && !sync_r;

  always_comb begin
    evt = 1'b0;
    if (t.source == `SRC_PIN_EDGE) evt = fall;
    else if (t.block_mode && !t.source[2]) evt = timer_match[t.source[1:0]];
  end

  // Event wins over a same-cycle acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pending_r <= 1'b0;
    else if (!t.enable) pending_r <= 1'b0;
    else if (evt) pending_r <= 1'b1;
    else if (t.ack) pending_r <= 1'b0;
  end

  // Unavailable codes give no request
  always_comb begin
    t.req = 1'b0;
    if (t.enable) begin
      if (t.block_mode) t.req = pending_r;
      else unique case (t.source)
        `SRC_AUTO_BURST, `SRC_AUTO_STEAL: t.req = 1'b1;
        `SRC_PIN_EDGE:                   t.req = pending_r;
        `SRC_PIN_LEVEL:                  t.req = !sync_r;
        default:                         t.req = 1'b0;
      endcase
    end
  end
  assign t.pending = pending_r;

  a_level_request: assert property (@(posedge pclk) disable iff (!presetn)
    (t.enable && !t.block_mode && t.source == `SRC_PIN_LEVEL && !sync_r) |-> t.req)
    else $error("low request pin did not raise a request");
  a_edge_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (t.enable && t.source == `SRC_PIN_EDGE && fall) |=> pending_r)
    else $error("falling pin edge was not latched");
  a_timer_select: assert property (@(posedge pclk) disable iff (!presetn)
    (t.enable && t.block_mode && t.source == 3'h1 && timer_match[1]) |=> t.req)
    else $error("timer channel 1 event did not request");
endmodule // dma_trigger

// ---- dma_request_partner.sv ----
// Far side model: timer event pulses, request pin and a stalling sink
// Assumes the channel output handshake and all requests run on pclk
`timescale 1ns/10ps
module dma_request_partner (
  input  wire logic        pclk,
  input  wire logic        out_valid,
  input  wire logic [15:0] out_data,
  input  wire logic [23:0] out_src_addr,
  input  wire logic [23:0] out_dst_addr,
  input  wire logic        out_word,
  output logic             out_ready,
  output logic             ext_req_n,
  output logic [3:0]       timer_match
);
  logic        stall = 1'b0;
  logic [23:0] q_dst[$];
  logic [23:0] q_src[$];
  logic [16:0] q_dat[$];
  initial begin
    out_ready = 1'b1;
    ext_req_n = 1'b1;
    timer_match = 4'h0;
  end
  // Records accepted transfers; refuses every other cycle while stalling
  always @(posedge pclk) begin
    if (out_valid && out_ready) begin
      q_dst.push_back(out_dst_addr);
      q_src.push_back(out_src_addr);
      q_dat.push_back({out_word, out_data});
    end
    out_ready <= stall ? ~out_ready : 1'b1;
  end
  task automatic pulse(input int ch);
    @(posedge pclk);
    timer_match <= 4'h1 << ch;
    @(posedge pclk);
    timer_match <= 4'h0;
  endtask
  task automatic set_pin(input logic v);
    @(posedge pclk);
    ext_req_n <= v;
  endtask
endmodule // dma_request_partner

// ---- dma_channel_b_full_address_control_test.sv ----
// Self-checking bench: registers, activation sources, address stepping, buffer
// Assumes dma_regs.svh, dma_pkg, the design and dma_request_partner compiled
`timescale 1ns/10ps
`include "dma_regs.svh"
module dma_channel_b_full_address_control_test;
  localparam logic [11:0] A_SRC = 12'(`IDX_SRC_ADDR * 4);
  localparam logic [11:0] A_CA  = 12'(`IDX_CTRL_A * 4);
  localparam logic [11:0] A_DST = 12'(`IDX_DST_ADDR * 4);
  localparam logic [11:0] A_CB  = 12'(`IDX_CTRL_B * 4);
  localparam logic [11:0] A_LEN = 12'(`IDX_BLOCK_LEN * 4);
  localparam logic [11:0] A_IO  = 12'(`IDX_IOADDR_1A * 4);
  logic        pclk = 1'b0;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic        in_valid;
  logic [15:0] in_data;
  logic [31:0] prdata;
  logic        pready, pslverr, ext_req_n, in_ready, out_valid, out_ready, out_word;
  logic [3:0]  timer_match;
  logic [15:0] out_data;
  logic [23:0] out_src_addr, out_dst_addr;
  logic [15:0] sent[$];
  logic [15:0] next_val = 16'h1357;
  int          num_errors = 0;
  int          checks_done = 0;

  dma_channel_b_full_address_control dut (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .ext_req_n, .timer_match, .in_valid,
    .in_ready, .in_data, .out_valid, .out_ready, .out_data, .out_src_addr,
    .out_dst_addr, .out_word);
  dma_request_partner partner (.pclk, .out_valid, .out_data, .out_src_addr,
    .out_dst_addr, .out_word, .out_ready, .ext_req_n, .timer_match);

  always #25 pclk = ~pclk;

  task automatic wrap_up();
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang(input string what);
    chk(what, 32'h0, 32'h1);
    wrap_up();
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) hang("pready wait");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp,
                       input logic experr);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    chk(what, exp, r);
    chk("pslverr", {31'h0, experr}, {31'h0, e});
  endtask
  task automatic setup(input logic [31:0] ca, input logic [23:0] d, input logic [23:0] s,
                       input logic [31:0] cb);
    wr(A_CA, ca);
    wr(A_DST, {8'h00, d});
    wr(A_SRC, {8'h00, s});
    wr(A_CB, cb);
  endtask
  task automatic push(input int n);
    int k;
    repeat (n) begin
      @(posedge pclk);
      in_valid <= 1'b1;
      in_data <= next_val;
      for (k = 0; k < 50; k++) begin
        @(posedge pclk);
        if (in_ready === 1'b1) break;
      end
      if (k == 50) hang("in_ready wait");
      sent.push_back(next_val);
      in_valid <= 1'b0;
      in_data <= ~next_val;
      next_val = next_val + 16'h1111;
    end
  endtask
  task automatic expect_xfers(input int n, input logic [23:0] d0, input int ds,
                              input logic [23:0] s0, input int ss, input logic word);
    int k;
    logic [15:0] d;
    for (k = 0; k < 400 && partner.q_dst.size() < n; k++) @(posedge pclk);
    if (k == 400) hang("transfer wait");
    for (k = 0; k < n; k++) begin
      d = sent.pop_front();
      chk("dst addr", 24'(d0 + k * ds), partner.q_dst.pop_front());
      chk("src addr", 24'(s0 + k * ss), partner.q_src.pop_front());
      chk("data", {word, word ? d : {8'h00, d[7:0]}}, partner.q_dat.pop_front());
    end
  endtask
  task automatic no_xfer(input int c);
    repeat (c) @(posedge pclk);
    chk("extra transfers", 32'h0, partner.q_dst.size());
  endtask

  task automatic s_regs();
    rdchk("ctrl_b reset", A_CB, 32'h0, 1'b0);
    wr(A_CB, 32'h5A);
    rdchk("ctrl_b", A_CB, 32'h5A, 1'b0);
    wr(A_IO, 32'hA5);
    rdchk("io addr", A_IO, 32'hA5, 1'b0);
    rdchk("unmapped", 12'hFFC, 32'h0, 1'b1);
    wr(A_CB, 32'h0);
  endtask
  task automatic s_burst();
    setup(32'h10, 24'h000100, 24'h000200, 32'h10);
    push(8);
    @(posedge pclk);
    in_valid <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("in_ready full", 32'h0, {31'h0, in_ready});
    in_valid <= 1'b0;
    no_xfer(20);
    partner.stall <= 1'b1;
    wr(A_CB, 32'h90);
    expect_xfers(8, 24'h000100, 1, 24'h000200, 1, 1'b0);
    partner.stall <= 1'b0;
    no_xfer(10);
  endtask
  task automatic s_normal(input logic [31:0] ca, input logic [31:0] cb, input int ds,
                          input int ss, input logic word);
    setup(ca, 24'h001000, 24'h002000, cb);
    push(3);
    expect_xfers(3, 24'h001000, ds, 24'h002000, ss, word);
    wr(A_CB, 32'h0);
  endtask
  task automatic s_pin();
    setup(32'h00, 24'h000500, 24'h000600, 32'h86);
    push(3);
    no_xfer(10);
    partner.set_pin(1'b0);
    expect_xfers(1, 24'h000500, 0, 24'h000600, 0, 1'b0);
    no_xfer(20);
    partner.set_pin(1'b1);
    wr(A_CB, 32'h87);
    no_xfer(10);
    partner.set_pin(1'b0);
    expect_xfers(2, 24'h000500, 0, 24'h000600, 0, 1'b0);
    partner.set_pin(1'b1);
    wr(A_CB, 32'h0);
  endtask
  task automatic s_block();
    int c;
    wr(A_LEN, 32'h02);
    // The loop programs timer codes 0 to 3; unavailable level code 7 and pin edge code 6 follow
    for (c = 0; c < 4; c++) begin
      setup(32'h11, 24'h000300, 24'h000400, 32'h90 + (c % 2) * 8 + c);
      push(2);
      partner.pulse((c + 1) % 4);
      no_xfer(10);
      partner.pulse(c);
      expect_xfers(2, 24'h000300, 1, 24'h000400, 1, 1'b0);
      repeat (4) @(posedge pclk);
      rdchk("dst after block", A_DST, c % 2 ? 32'h302 : 32'h300, 1'b0);
      rdchk("src after block", A_SRC, c % 2 ? 32'h400 : 32'h402, 1'b0);
    end
    setup(32'h11, 24'h000700, 24'h000800, 32'h97);
    push(2);
    partner.set_pin(1'b0);
    no_xfer(20);
    partner.set_pin(1'b1);
    repeat (4) @(posedge pclk);
    wr(A_CB, 32'h96);
    partner.set_pin(1'b0);
    expect_xfers(2, 24'h000700, 1, 24'h000800, 1, 1'b0);
    partner.set_pin(1'b1);
    wr(A_CB, 32'h0);
  endtask

  initial begin
    presetn <= 1'b0;
    paddr <= 12'h000;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    pwdata <= 32'h0;
    in_valid <= 1'b0;
    in_data <= 16'h0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_burst();
    s_normal(32'h70, 32'hB2, -2, -2, 1'b1);
    s_normal(32'h40, 32'hA0, 0, 0, 1'b1);
    s_normal(32'h20, 32'h80, 0, 0, 1'b0);
    s_pin();
    s_block();
    wrap_up();
  end
endmodule // dma_channel_b_full_address_control_test
